// *** dws_sequencer.sv ***
/*
  Timed waveform sequencer: register slave, trigger, delays, stop modes,
  data FIFO with replay or DMA streaming, and the converter update strobe.
  Assumes trigger and DMA inputs synchronous to clock and a one-cycle
  reference tick pulse supplied by a divider.
*/
`timescale 1ns/1ns
module dws_sequencer
  import dws_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic reference_tick_clock,
  input wire logic analog_trig,
  input wire logic digital_trig,
  input wire logic dma_valid,
  input wire logic [2*SMP_W-1:0] dma_data,
  output logic dma_ready,
  output logic dac_update_strobe,
  output logic [SMP_W-1:0] dac_data_ch0,
  output logic [SMP_W-1:0] dac_data_ch1,
  output logic busy
);
  typedef enum logic [1:0] {S_IDLE, S_DLY1, S_RUN, S_GAP} dws_state_t;

  function automatic logic [31:0] dws_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : dws_merge

  function automatic logic [23:0] dws_min1(input logic [23:0] v);
    return (v == 24'h000000) ? 24'h000001 : v;
  endfunction : dws_min1

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  dws_ctrl_t ctrl_reg;
  logic [UI_W-1:0] ui_reg;
  logic [UC_W-1:0] uc_reg;
  logic [IC_W-1:0] ic_reg;
  logic [DLY_W-1:0] dly1_reg;
  logic [DLY_W-1:0] dly2_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic wr_en;
  logic armed_reg;
  logic stop_pend_reg;
  logic under_reg;
  logic [CNT_W-1:0] fcnt_reg;
  dws_state_t st;

  assign wr_en = avs_write && !wait_reg;
  assign wr_val = dws_merge(rd_mux, avs_writedata, avs_byteenable);
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  always_comb
  begin
    unique case (avs_address)
      OFS_CTRL: rd_mux = {22'h000000, ctrl_reg};
      OFS_UI: rd_mux = {8'h00, ui_reg};
      OFS_UC: rd_mux = {8'h00, uc_reg};
      OFS_IC: rd_mux = {8'h00, ic_reg};
      OFS_DLY1: rd_mux = {16'h0000, dly1_reg};
      OFS_DLY2: rd_mux = {16'h0000, dly2_reg};
      OFS_STATUS: rd_mux = {5'h00, fcnt_reg, 10'h000, under_reg, stop_pend_reg, st, busy, armed_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // One wait cycle, then the access completes
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if (avs_read && wait_reg)
        rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= dws_ctrl_t'(CTRL_RST);
      ui_reg <= 24'h000000;
      uc_reg <= 24'h000000;
      ic_reg <= 24'h000000;
      dly1_reg <= 16'h0000;
      dly2_reg <= 16'h0000;
    end
    else if (wr_en)
    begin
      unique case (avs_address)
        OFS_CTRL: ctrl_reg <= dws_ctrl_t'(wr_val[CTRL_W-1:0]);
        OFS_UI: ui_reg <= wr_val[UI_W-1:0];
        OFS_UC: uc_reg <= wr_val[UC_W-1:0];
        OFS_IC: ic_reg <= wr_val[IC_W-1:0];
        OFS_DLY1: dly1_reg <= wr_val[DLY_W-1:0];
        OFS_DLY2: dly2_reg <= wr_val[DLY_W-1:0];
        default: ;
      endcase
    end
  end

  logic cmd_wr;
  logic cmd_arm;
  logic cmd_trig;
  logic cmd_stop;
  logic cmd_flush;
  assign cmd_wr = wr_en && (avs_address == OFS_CMD) && avs_byteenable[0];
  assign cmd_arm = cmd_wr && avs_writedata[CMD_ARM];
  assign cmd_trig = cmd_wr && avs_writedata[CMD_TRIG];
  assign cmd_stop = cmd_wr && avs_writedata[CMD_STOP];
  assign cmd_flush = cmd_wr && avs_writedata[CMD_FLUSH];

  // ---------------------------------------------------------------
  // Trigger and timing
  // ---------------------------------------------------------------
  logic atrig_prev;
  logic dtrig_prev;
  logic trig_sel;
  logic trig_ok;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      atrig_prev <= 1'b0;
      dtrig_prev <= 1'b0;
    end
    else
    begin
      atrig_prev <= analog_trig;
      dtrig_prev <= digital_trig;
    end
  end

  always_comb
  begin
    unique case (ctrl_reg.trig_src)
      TRIG_ANALOG: trig_sel = analog_trig && !atrig_prev;
      TRIG_DIGITAL: trig_sel = digital_trig && !dtrig_prev;
      default: trig_sel = cmd_trig;
    endcase
  end
  // Only an armed idle sequencer listens
  assign trig_ok = trig_sel && armed_reg && (st == S_IDLE);

  logic [UI_W-1:0] ui_cnt;
  logic [UI_W-1:0] ui_m1;
  logic period_tick;
  logic dly_tick;
  logic start_reg;
  dws_state_t st_next;
  assign ui_m1 = dws_min1(ui_reg) - 24'h000001;
  assign period_tick = reference_tick_clock && (ui_cnt >= ui_m1);
  assign dly_tick = ((st == S_DLY1) ? ctrl_reg.start_clk_sel : ctrl_reg.gap_clk_sel)
                    ? period_tick : reference_tick_clock;

  always_ff @(posedge clock)
  begin
    if (sys_rst || st == S_IDLE || st_next != st || period_tick)
      ui_cnt <= 24'h000000;
    else if (reference_tick_clock)
      ui_cnt <= ui_cnt + 24'h000001;
  end

  // ---------------------------------------------------------------
  // Waveform sequencing
  // ---------------------------------------------------------------
  logic [DLY_W-1:0] delay_cnt;
  logic [UC_W-1:0] uidx;
  logic [IC_W-1:0] grp;
  logic [UC_W-1:0] uc_eff;
  logic fire;
  logic wave_end;
  logic grp_end;
  logic stop_hit;
  logic stop_imm;
  logic finish;
  logic do_strobe;
  logic replay;
  logic [CNT_W-1:0] cap;

  assign uc_eff = dws_min1(uc_reg);
  assign stop_hit = stop_pend_reg || cmd_stop;
  assign stop_imm = cmd_stop && ctrl_reg.stop_mode != STOP_WAVE && ctrl_reg.stop_mode != STOP_GROUP;
  assign fire = (st == S_RUN) && (start_reg || period_tick);
  assign wave_end = fire && (uidx == uc_eff);
  assign grp_end = (grp + 24'h000001) >= dws_min1(ic_reg);
  // Group end is also the finite end; infinite needs a group stop
  assign finish = (stop_hit && ctrl_reg.stop_mode == STOP_WAVE)
                  || (grp_end && (!ctrl_reg.infinite || (stop_hit && ctrl_reg.stop_mode == STOP_GROUP)));
  assign do_strobe = fire && !stop_imm && (!wave_end || (!finish && dly2_reg == 16'h0000));

  always_comb
  begin
    st_next = st;
    unique case (st)
      S_IDLE: if (trig_ok) st_next = ctrl_reg.delay_mode ? S_DLY1 : S_RUN;
      S_DLY1: if (cmd_stop) st_next = S_IDLE;
        else if (delay_cnt == 16'h0000) st_next = S_RUN;
      S_RUN: if (stop_imm || (wave_end && finish)) st_next = S_IDLE;
        else if (wave_end && dly2_reg != 16'h0000) st_next = S_GAP;
      S_GAP: if (stop_imm || (stop_hit && ctrl_reg.stop_mode == STOP_WAVE)) st_next = S_IDLE;
        else if (delay_cnt == 16'h0000) st_next = S_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st <= S_IDLE;
      start_reg <= 1'b0;
    end
    else
    begin
      st <= st_next;
      start_reg <= (st_next == S_RUN) && (st != S_RUN);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      delay_cnt <= 16'h0000;
    else if (trig_ok)
      delay_cnt <= dly1_reg;
    else if (wave_end)
      delay_cnt <= dly2_reg;
    else if ((st == S_DLY1 || st == S_GAP) && dly_tick && delay_cnt != 16'h0000)
      delay_cnt <= delay_cnt - 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || trig_ok)
      grp <= 24'h000000;
    else if (wave_end)
      grp <= grp_end ? 24'h000000 : grp + 24'h000001;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || (st_next == S_RUN && st != S_RUN))
      uidx <= 24'h000000;
    else if (do_strobe)
      uidx <= wave_end ? 24'h000001 : uidx + 24'h000001;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      armed_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
    end
    else
    begin
      if (cmd_stop || stop_imm)
        armed_reg <= 1'b0;
      else if (cmd_arm)
        armed_reg <= 1'b1;
      else if (st == S_RUN && st_next == S_IDLE)
        armed_reg <= ctrl_reg.retrig_en;
      if (st_next == S_IDLE)
        stop_pend_reg <= 1'b0;
      else if (cmd_stop)
        stop_pend_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Data FIFO
  // ---------------------------------------------------------------
  logic [2*SMP_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr;
  logic [FIFO_AW-1:0] rptr;
  logic [FIFO_AW-1:0] raddr;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] fcnt_next;
  logic push;
  logic pop;

  assign cap = ctrl_reg.dual_ch ? CAP_DUAL : CAP_SINGLE;
  assign replay = uc_eff < {13'h0000, cap};
  // Replay loads one waveform only; streaming keeps the FIFO topped up
  assign limit = replay ? uc_eff[CNT_W-1:0] : cap;
  assign push = dma_valid && dma_ready;
  assign pop = do_strobe && !replay && fcnt_reg != 11'h000;
  assign raddr = replay ? rptr + (wave_end ? 10'h000 : uidx[FIFO_AW-1:0]) : rptr;
  assign fcnt_next = fcnt_reg + {10'h000, push} - {10'h000, pop};

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wptr] <= dma_data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || cmd_flush)
    begin
      wptr <= 10'h000;
      rptr <= 10'h000;
      fcnt_reg <= 11'h000;
      dma_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wptr <= (wptr + 10'h001) & (cap[FIFO_AW-1:0] - 10'h001);
      if (pop)
        rptr <= (rptr + 10'h001) & (cap[FIFO_AW-1:0] - 10'h001);
      fcnt_reg <= fcnt_next;
      dma_ready <= fcnt_next < limit;
    end
  end

  // ---------------------------------------------------------------
  // Converter outputs
  // ---------------------------------------------------------------
  // Data and strobe rise together, so the converter latches fresh data
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dac_update_strobe <= 1'b0;
      dac_data_ch0 <= 12'h000;
      dac_data_ch1 <= 12'h000;
      busy <= 1'b0;
      under_reg <= 1'b0;
    end
    else
    begin
      dac_update_strobe <= do_strobe;
      busy <= st_next != S_IDLE;
      if (do_strobe && !replay && fcnt_reg == 11'h000)
        under_reg <= 1'b1;
      else if (wr_en && avs_address == OFS_STATUS && wr_val[STAT_UNDER])
        under_reg <= 1'b0;
      if (do_strobe)
      begin
        dac_data_ch0 <= mem[raddr][SMP_W-1:0];
        if (ctrl_reg.dual_ch)
          dac_data_ch1 <= mem[raddr][2*SMP_W-1:SMP_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_post_immediate: assert property (trig_ok && !ctrl_reg.delay_mode && !cmd_stop |-> ##2 dac_update_strobe)
    else $error("post trigger did not strobe at once");
  a_busy_ignore: assert property (st == S_DLY1 && trig_sel && !dly_tick && delay_cnt != 16'h0000 |=> $stable(delay_cnt))
    else $error("trigger disturbed running delay");
  a_delay_count: assert property (st == S_DLY1 && dly_tick && delay_cnt != 16'h0000 && !cmd_stop
    |=> delay_cnt == $past(delay_cnt) - 16'h0001)
    else $error("start delay did not count down");
  a_delay_zero: assert property (st == S_DLY1 && delay_cnt == 16'h0000 && !cmd_stop |=> st == S_RUN ##1 dac_update_strobe)
    else $error("start delay end did not start waveform");
  a_gap_zero: assert property (st == S_GAP && delay_cnt == 16'h0000 && !cmd_stop |=> st == S_RUN)
    else $error("gap end did not restart waveform");
  a_stop_now: assert property (stop_imm && st != S_IDLE |=> st == S_IDLE ##1 !dac_update_strobe[*2])
    else $error("immediate stop kept strobing");
  a_stop_wave: assert property (wave_end && stop_pend_reg && ctrl_reg.stop_mode == STOP_WAVE |=> st == S_IDLE)
    else $error("stop mode two ran past waveform");
  a_replay_hold: assert property (do_strobe && replay && !push |=> fcnt_reg == $past(fcnt_reg))
    else $error("replay consumed FIFO data");
  a_fifo_cap: assert property (fcnt_reg <= cap)
    else $error("FIFO count above capacity");
  a_strobe_pulse: assert property (dac_update_strobe && ui_reg > 24'h000001 |=> !dac_update_strobe)
    else $error("strobe wider than one cycle");

  c_delay_start: cover property (st == S_DLY1 ##1 st == S_RUN);
  c_gap_run: cover property (st == S_GAP ##1 st == S_RUN);
  c_group_stop: cover property (wave_end && finish && ctrl_reg.stop_mode == STOP_GROUP && ctrl_reg.infinite);
  c_retrigger: cover property (st == S_RUN ##1 st == S_IDLE && armed_reg);
endmodule : dws_sequencer

// *** dws_pkg.sv ***
/*
  Constants, register map and carrier types for the DAC waveform sequencer.
  Assumes one 50 MHz system clock and Avalon-MM register access.
*/
// Summary of operation
// - Post-trigger starts updates at once, no delay
// - Trigger from software, analog or digital source
// - Start delay counts down per tick, zero starts
// - Start delay 16 bits, reference_tick_clock or period clock
// - Re-trigger enable lets later triggers restart
// - Triggers during generation are ignored
// - Iteration count repeats; infinite runs until stop
// - Iteration count groups waveforms in stop mode three
// - Short waveform replays FIFO without refetch
// - Long waveform refills FIFO by DMA
// - FIFO holds 1024 single, 512 dual entries
// - Gap delay runs after waveform, zero restarts
// - Gap delay 16 bits, reference_tick_clock or period clock
// - Three stop modes, finite and infinite alike
// - Stop mode one halts strobes immediately
// - Stop mode two finishes current waveform
// - Stop mode three finishes iteration group
// - One sample per rising update strobe
// - Update count 24 bits, one waveform length
// - Iteration count 24 bits for finite mode
package dws_pkg;
  localparam int UI_W = 24;
  localparam int UC_W = 24;
  localparam int IC_W = 24;
  localparam int DLY_W = 16;
  localparam int SMP_W = 12;
  localparam int FIFO_DEPTH = 1024;
  localparam int FIFO_AW = 10;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] CAP_SINGLE = 11'h400;
  localparam logic [CNT_W-1:0] CAP_DUAL = 11'h200;
  localparam int MIN_UI_TICKS = 40;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_UI = 6'h08;
  localparam logic [5:0] OFS_UC = 6'h0c;
  localparam logic [5:0] OFS_IC = 6'h10;
  localparam logic [5:0] OFS_DLY1 = 6'h14;
  localparam logic [5:0] OFS_DLY2 = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;

  localparam int CMD_ARM = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_FLUSH = 3;
  localparam int STAT_UNDER = 5;

  typedef enum logic [1:0] {TRIG_SW, TRIG_ANALOG, TRIG_DIGITAL} dws_trig_t;
  typedef enum logic [1:0] {STOP_NOW, STOP_WAVE, STOP_GROUP} dws_stop_t;

  typedef struct packed {
    logic dual_ch;
    dws_stop_t stop_mode;
    dws_trig_t trig_src;
    logic gap_clk_sel;
    logic start_clk_sel;
    logic infinite;
    logic retrig_en;
    logic delay_mode;
  } dws_ctrl_t;

  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
endpackage : dws_pkg

// *** dws_far_model.sv ***
/*
  Far-side model: host DMA feeder pushing samples and converter capturing updates.
  Assumes the sequencer's clock and sync reset; samples k are {200h+k, 100h+k}.
*/
`timescale 1ns/1ns
module dws_far_model
  import dws_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic feed_en,
  input wire logic [31:0] cyc,
  input wire logic dma_ready,
  input wire logic dac_update_strobe,
  input wire logic [SMP_W-1:0] dac_data_ch0,
  input wire logic [SMP_W-1:0] dac_data_ch1,
  output logic dma_valid,
  output logic [2*SMP_W-1:0] dma_data,
  output logic [31:0] strobe_cnt,
  output logic [31:0] pushed
);
  logic [2*SMP_W-1:0] seen [0:2047];
  logic [31:0] stamp [0:2047];
  logic [11:0] nx;

  assign nx = pushed[11:0] + {11'h000, dma_valid & dma_ready};

  // ----------------------------------------
  // Host DMA side
  // ----------------------------------------
  // A pending word is held until taken; idle data toggles so stale values never match
  always_ff @(posedge clock)
    if (sys_rst)
    begin
      dma_valid <= 1'b0;
      dma_data <= 24'h5a5a5a;
      pushed <= 32'h0;
    end
    else
    begin
      if (dma_valid && dma_ready)
        pushed <= pushed + 32'h1;
      if (!dma_valid || dma_ready)
      begin
        dma_valid <= feed_en;
        dma_data <= feed_en ? {12'h200 + nx, 12'h100 + nx} : ~dma_data;
      end
    end

  // ----------------------------------------
  // Converter side
  // ----------------------------------------
  always_ff @(posedge clock)
    if (sys_rst)
      strobe_cnt <= 32'h0;
    else if (dac_update_strobe)
    begin
      seen[strobe_cnt[10:0]] <= {dac_data_ch1, dac_data_ch0};
      stamp[strobe_cnt[10:0]] <= cyc;
      strobe_cnt <= strobe_cnt + 32'h1;
    end
endmodule : dws_far_model

// *** tb_dac_waveform_sequencer.sv ***
/*
  Self-checking bench for the waveform sequencer over its Avalon-MM registers.
  Assumes the far-side model file; reference_tick_clock tick pulses every second clock.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (e)); end end
`define SN(i) dws_far_model_i.seen[i]
`define ST(i) dws_far_model_i.stamp[i]
module tb_dac_waveform_sequencer
  import dws_pkg::*;
;
  logic clock, sys_rst, avs_read, avs_write, reference_tick_clock, analog_trig, digital_trig, feed_en;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, strobe_cnt, pushed;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, dma_valid, dma_ready, dac_update_strobe, busy;
  logic [2*SMP_W-1:0] dma_data;
  logic [SMP_W-1:0] dac_data_ch0, dac_data_ch1;
  int cyc, fail_count, checks_done, b, t0, n, p0, e;

  dws_sequencer dws_sequencer_i (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reference_tick_clock(reference_tick_clock), .analog_trig(analog_trig), .digital_trig(digital_trig),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
    .dac_update_strobe(dac_update_strobe), .dac_data_ch0(dac_data_ch0), .dac_data_ch1(dac_data_ch1),
    .busy(busy));
  dws_far_model dws_far_model_i (.clock(clock), .sys_rst(sys_rst), .feed_en(feed_en), .cyc(cyc),
    .dma_ready(dma_ready), .dac_update_strobe(dac_update_strobe), .dac_data_ch0(dac_data_ch0),
    .dac_data_ch1(dac_data_ch1), .dma_valid(dma_valid), .dma_data(dma_data),
    .strobe_cnt(strobe_cnt), .pushed(pushed));

  // ----------------------------------------
  // Clock, reference_tick_clock tick and timeout
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Longest run is the 512-update stream at 80 clocks per update
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    reference_tick_clock <= ~reference_tick_clock;
    if (cyc == 60000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic cfg(input logic [31:0] c, ui, uc, ic, d1, d2);
    wr(OFS_CTRL, c);
    wr(OFS_UI, ui);
    wr(OFS_UC, uc);
    wr(OFS_IC, ic);
    wr(OFS_DLY1, d1);
    wr(OFS_DLY2, d2);
    wr(OFS_CMD, 32'h1);
  endtask : cfg

  // Source 0 is the software command, 1 analog, 2 digital
  task automatic fire(input int s);
    b = strobe_cnt;
    if (s == 0)
      wr(OFS_CMD, 32'h2);
    else
    begin
      @(posedge clock);
      analog_trig <= (s == 1);
      digital_trig <= (s == 2);
      @(posedge clock);
      analog_trig <= 1'b0;
      digital_trig <= 1'b0;
    end
    t0 = cyc;
  endtask : fire

  task automatic wait_busy(input logic v);
    do @(posedge clock); while (busy !== v);
  endtask : wait_busy

  function automatic logic [23:0] pat(input int k);
    return {12'h200 + k[11:0], 12'h100 + k[11:0]};
  endfunction : pat

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    reference_tick_clock = 1'b0;
    analog_trig = 1'b0;
    digital_trig = 1'b0;
    feed_en = 1'b0;
    cyc = 0;
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    acc(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    wr(OFS_CTRL, 32'h2a5);
    acc(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h2a5)
    acc(1'b0, 6'h20, 32'h0);
    `CHK(rd, 32'h0)
    $display("test registers done");

    // Dual channel, post trigger, two iterations replayed from a 4-word load
    cfg(32'h200, 32'd40, 32'd4, 32'd2, 32'd0, 32'd0);
    wr(OFS_CMD, 32'h8);
    p0 = pushed;
    feed_en <= 1'b1;
    do @(posedge clock); while (pushed < p0 + 4);
    feed_en <= 1'b0;
    fire(0);
    wait_busy(1'b1);
    wr(OFS_CMD, 32'h2);
    wait_busy(1'b0);
    `CHK(strobe_cnt - b, 8)
    `CHK(`ST(b) - t0 <= 3, 1'b1)
    `CHK(`ST(b + 2) - `ST(b + 1), 80)
    for (int k = 0; k < 8; k++)
      `CHK(`SN(b + k), pat(p0 + k % 4))
    acc(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[26:16], 11'h004)
    $display("test post trigger done");

    for (int s = 1; s < 3; s++)
    begin
      cfg(32'h202 | (s << 5), 32'd40, 32'd4, 32'd1, 32'd0, 32'd0);
      fire(3 - s);
      repeat (8) @(posedge clock);
      `CHK(busy, 1'b0)
      fire(s);
      wait_busy(1'b1);
      wait_busy(1'b0);
      `CHK(strobe_cnt - b, 4)
      fire(s);
      wait_busy(1'b1);
      wait_busy(1'b0);
      `CHK(strobe_cnt - b, 4)
    end
    $display("test sources done");

    for (int s = 0; s < 2; s++)
    begin
      n = s ? 1 : 5;
      e = s ? 80 : 10;
      cfg(32'h201 | (s << 3) | (s << 4), 32'd40, 32'd4, 32'd2, n, n);
      fire(0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      `CHK((`ST(b) - t0 >= e) && (`ST(b) - t0 <= e + 5), 1'b1)
      `CHK((`ST(b + 4) - `ST(b + 3) >= 80 + e) && (`ST(b + 4) - `ST(b + 3) <= 84 + e), 1'b1)
    end
    $display("test delays done");

    for (int m = 0; m < 3; m++)
    begin
      cfg(32'h204 | (m << 7), 32'd40, 32'd4, 32'd3, 32'd0, 32'd0);
      fire(0);
      do @(posedge clock); while (strobe_cnt < b + 6);
      wr(OFS_CMD, 32'h4);
      wait_busy(1'b0);
      `CHK(strobe_cnt - b, (m == 0) ? 6 : (m == 1) ? 8 : 12)
    end
    $display("test stop modes done");

    // 512 words in dual mode are not below the 512-entry capacity, so the FIFO streams and refills
    cfg(32'h200, 32'd40, 32'd512, 32'd1, 32'd0, 32'd0);
    wr(OFS_CMD, 32'h8);
    p0 = pushed;
    feed_en <= 1'b1;
    do @(posedge clock); while (pushed < p0 + 512);
    fire(0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    feed_en <= 1'b0;
    `CHK(strobe_cnt - b, 512)
    `CHK(`SN(b + 511), pat(p0 + 511))
    `CHK(pushed - p0 > 512, 1'b1)
    acc(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[STAT_UNDER], 1'b0)
    $display("test stream done");
    close_out();
  end
endmodule : tb_dac_waveform_sequencer
